// file: dhi_checker.sv
// Purpose: Port-level assertions for the hub interrupt logic
// Assumes: Only the top-level ports are visible
// Notes:   Shadows main control and pin control writes
`timescale 1ns/1ps
module dhi_checker (
  // Clock and reset
  input wire logic                          core_clk,
  input wire logic                          arst_n,
  // Register port
  input wire logic [7:0]                    regAddr,
  input wire logic                          regWrEn,
  input wire logic [7:0]                    regWrData,
  input wire logic                          regRdEn,
  input wire logic [7:0]                    regRdData,
  // Interrupt and pins
  input wire logic                          irqOut_n,
  input wire logic [dhi_pkg::NUM_PINS-1:0]  pinOut,
  input wire logic [dhi_pkg::NUM_PINS-1:0]  pinOe_n
);
  import dhi_pkg::*;
  logic       gateOn_r;
  logic [7:0] pinCtl_r [NUM_PINS];
  logic       pin3Irq;
  logic       pin5Irq;
  logic       pin5Reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      gateOn_r <= 1'b0;
      for (int i = 0; i < NUM_PINS; i++)
        pinCtl_r[i] <= RST_ZERO;
    end else if (regWrEn) begin
      if (regAddr == ADDR_MAIN_CTL)
        gateOn_r <= regWrData[MAIN_GATE_BIT];
      if (regAddr[7:3] == ADDR_PIN_CTL_BASE[7:3])
        pinCtl_r[regAddr[2:0]] <= regWrData;
    end
  end

  assign pin3Irq = (pinCtl_r[3][7:5] == PIN_SRC_IRQ) && pinCtl_r[3][PIN_OE_BIT];
  assign pin5Irq = (pinCtl_r[5][7:5] == PIN_SRC_IRQ) && pinCtl_r[5][PIN_OE_BIT];
  assign pin5Reg = (pinCtl_r[5][7:5] == PIN_SRC_REG);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  AST_RD_HOLD: assert property (!$past(regRdEn) && !$past(regRdEn, 2) |-> $stable(regRdData))
    else $error("read data moved without a read");
  AST_UNMAPPED_ZERO: assert property (regRdEn && regAddr == 8'h00 ##1 !regRdEn |=> regRdData == RST_ZERO)
    else $error("unmapped read returned nonzero");
  AST_GATE_QUIET: assert property (!gateOn_r && !$past(gateOn_r) |-> irqOut_n)
    else $error("interrupt asserted with gate clear");
  AST_FALL_GATED: assert property ($fell(irqOut_n) |-> $past(gateOn_r))
    else $error("interrupt fell without gate");
  AST_RISE_CAUSE: assert property ($rose(irqOut_n) |-> $past(regRdEn, 2) || $past(regWrEn, 2))
    else $error("interrupt released without an access");
  AST_OD_PIN_IRQ: assert property (pin3Irq |-> pinOe_n[OPEN_DRAIN_PIN] == irqOut_n)
    else $error("open drain pin does not follow interrupt");
  AST_PP_PIN_IRQ: assert property (pin5Irq |-> pinOut[5] == irqOut_n && !pinOe_n[5])
    else $error("routed pin does not follow interrupt");
  AST_PP_PIN_REG: assert property (pin5Reg |-> pinOut[5] == pinCtl_r[5][PIN_VAL_BIT] && pinOe_n[5] == !pinCtl_r[5][PIN_OE_BIT])
    else $error("register pin level wrong");
endmodule : dhi_checker

bind dhi_interrupt_logic dhi_checker u_chk (
  .core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
  .regRdEn(regRdEn), .regRdData(regRdData), .irqOut_n(irqOut_n), .pinOut(pinOut), .pinOe_n(pinOe_n)
);

// file: dhi_interrupt_logic.sv
// Purpose: Interrupt aggregation of a two-port serial-video deserializer hub
// Assumes: Sources are core_clk logic except forward-channel pins; reads clear flags
// Notes:
`timescale 1ns/1ps
module dhi_interrupt_logic (
  // Clock and reset
  input  wire logic                                         core_clk,
  input  wire logic                                         arst_n,
  // Register port
  input  wire logic [7:0]                                   regAddr,
  input  wire logic                                         regWrEn,
  input  wire logic [7:0]                                   regWrData,
  input  wire logic                                         regRdEn,
  output logic      [7:0]                                   regRdData,
  // Receive port sources
  input  wire logic [dhi_pkg::NUM_PORTS-1:0]                rxLock,
  input  wire logic [dhi_pkg::NUM_PORTS-1:0]                rxPass,
  input  wire logic [dhi_pkg::NUM_PORTS-1:0]                rxBccCrcErr,
  input  wire logic [dhi_pkg::NUM_PORTS-1:0]                rxBccSeqErr,
  input  wire logic [dhi_pkg::NUM_PORTS-1:0]                rxParityErr,
  input  wire logic [dhi_pkg::NUM_PORTS-1:0]                rxEncodeErr,
  input  wire logic [dhi_pkg::NUM_PORTS-1:0]                rxBufferErr,
  input  wire logic [dhi_pkg::NUM_PORTS-1:0]                rxLineLenChg,
  input  wire logic [dhi_pkg::NUM_PORTS-1:0]                rxLineCntChg,
  input  wire logic [dhi_pkg::NUM_PORTS-1:0][3:0]           rxCsiErr,
  input  wire logic [dhi_pkg::NUM_PORTS-1:0][31:0]          rxSensorStatus,
  input  wire logic [dhi_pkg::NUM_PORTS-1:0][dhi_pkg::NUM_FWD-1:0] rxFwdPin,
  // Transmit port sources
  input  wire logic                                         txPass,
  input  wire logic                                         txSync,
  input  wire logic                                         txPassDeassert,
  input  wire logic                                         txSyncLoss,
  // Interrupt and general pins
  output logic                                              irqOut_n,
  output logic      [dhi_pkg::NUM_PINS-1:0]                 pinOut,
  output logic      [dhi_pkg::NUM_PINS-1:0]                 pinOe_n
);
  import dhi_pkg::*;

  function automatic logic [7:0] stick(input logic [7:0] old, input logic [7:0] set, input logic clr);
    stick = (old & ~{8{clr}}) | set;
  endfunction : stick

  function automatic logic hit(input logic [7:0] a, input logic [7:0] want);
    hit = (a == want);
  endfunction : hit

  localparam int unsigned NP = NUM_PORTS;

  // Global registers
  logic [7:0] mainCtl_r;
  logic [7:0] portSel_r;
  logic [7:0] txEnable_r;
  logic [7:0] txFlags_r;
  logic [7:0] pinCtl_r [NUM_PINS];
  logic       txPassD_r;
  logic       txSyncD_r;
  logic       irqOut_n_r;
  logic [7:0] rdData_r;

  // Per-port registers
  logic [7:0] enUpper_r  [NP];
  logic [7:0] enLower_r  [NP];
  logic [7:0] fwdCtl_r   [NP];
  logic [7:0] fwdFlags_r [NP];
  logic [7:0] senRiseM_r [NP];
  logic [7:0] senFallM_r [NP];
  logic [7:0] senRiseF_r [NP];
  logic [7:0] senFallF_r [NP];
  logic [7:0] senPrev_r  [NP];
  logic [7:0] sts1Fl_r   [NP];
  logic [7:0] sts2Fl_r   [NP];
  logic [7:0] videoFl_r  [NP];
  logic       lockD_r    [NP];
  logic       passD_r    [NP];
  logic [NUM_FWD-1:0] fwdS1_r  [NP];
  logic [NUM_FWD-1:0] fwdS2_r  [NP];
  logic [NUM_FWD-1:0] fwdS3_r  [NP];
  logic [NUM_FWD-1:0] fwdVal_r [NP];

  // Decode of the register port
  wire        rdPort      = portSel_r[PSEL_RD_BIT];
  wire        rdSts1      = regRdEn && hit(regAddr, ADDR_RX_STS_FIRST);
  wire        rdSts2      = regRdEn && hit(regAddr, ADDR_RX_STS_SECOND);
  wire        rdVideo     = regRdEn && hit(regAddr, ADDR_VIDEO_RX_STS);
  wire        rdFwd       = regRdEn && hit(regAddr, ADDR_FWD_FLAGS);
  wire        rdSenRise   = regRdEn && hit(regAddr, ADDR_SEN_RISE_FL);
  wire        rdSenFall   = regRdEn && hit(regAddr, ADDR_SEN_FALL_FL);
  wire        rdTx        = regRdEn && hit(regAddr, ADDR_TX_FLAGS);
  wire        wrPinArea   = regAddr[7:3] == ADDR_PIN_CTL_BASE[7:3];
  wire        wrSensorArea = regAddr[7:2] == ADDR_SENSOR_BASE[7:2];

  // Per-port derived values
  logic [7:0] sts1Val    [NP];
  logic [7:0] sts2Val    [NP];
  logic [7:0] flUpper    [NP];
  logic [7:0] flLower    [NP];
  logic [7:0] senByte0   [NP];
  logic [7:0] senRiseSet [NP];
  logic [7:0] senFallSet [NP];
  logic [7:0] fwdSet     [NP];
  logic [7:0] sts1Set    [NP];
  logic [7:0] sts2Set    [NP];
  logic [NP-1:0] portPending;
  logic [NP-1:0] clrSts1;
  logic [NP-1:0] clrSts2;
  logic [NP-1:0] clrVideo;
  logic [NP-1:0] clrFwd;
  logic [NP-1:0] clrSenRise;
  logic [NP-1:0] clrSenFall;

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      clrSts1[p]    = rdSts1 && (rdPort == p[0]);
      clrSts2[p]    = rdSts2 && (rdPort == p[0]);
      clrVideo[p]   = (rdVideo || rdSts2) && (rdPort == p[0]);
      clrFwd[p]     = rdFwd && (rdPort == p[0]);
      clrSenRise[p] = rdSenRise && (rdPort == p[0]);
      clrSenFall[p] = rdSenFall && (rdPort == p[0]);
      senByte0[p]   = rxSensorStatus[p][7:0];
      senRiseSet[p] = senByte0[p] & ~senPrev_r[p] & senRiseM_r[p];
      senFallSet[p] = ~senByte0[p] & senPrev_r[p] & senFallM_r[p];
      fwdSet[p]     = {fwdVal_r[p] & ~fwdS2_r[p] & ~fwdS3_r[p] & fwdCtl_r[p][7:4],
                       ~fwdVal_r[p] & fwdS2_r[p] & fwdS3_r[p] & fwdCtl_r[p][3:0]};
      // Sticky bits: 5 crc, 4 lock change, 3 seq, 2 parity, 6 pass change
      sts1Set[p]    = {1'b0, (rxPass[p] != passD_r[p]), rxBccCrcErr[p], (rxLock[p] != lockD_r[p]),
                       rxBccSeqErr[p], rxParityErr[p], 2'b00};
      sts2Set[p]    = {1'b0, rxLineLenChg[p], rxEncodeErr[p], rxBufferErr[p], 3'b000, rxLineCntChg[p]};
      sts1Val[p]    = {1'b0, p[0], sts1Fl_r[p][5:2], rxPass[p], rxLock[p]};
      sts2Val[p]    = {1'b0, sts2Fl_r[p][6:4], |videoFl_r[p], 2'b00, sts2Fl_r[p][0]};
      flUpper[p]    = {3'b000, |fwdFlags_r[p], |(senRiseF_r[p] | senFallF_r[p]),
                       sts2Fl_r[p][5], sts1Fl_r[p][3], sts1Fl_r[p][5]};
      flLower[p]    = {1'b0, sts2Fl_r[p][6], sts2Fl_r[p][0], sts2Fl_r[p][4], |videoFl_r[p],
                       sts1Fl_r[p][2], sts1Fl_r[p][6], sts1Fl_r[p][4]};
      portPending[p] = |((flUpper[p] & enUpper_r[p]) | (flLower[p] & enLower_r[p]));
    end
  end

  // Main aggregation
  wire  [7:0] txFlagSet    = {3'b000, |portPending, txSyncLoss, txPassDeassert,
                              txSync & ~txSyncD_r, txPass & ~txPassD_r};
  wire        txPending    = |(txFlags_r & txEnable_r);
  wire  [NP-1:0] rxActive  = portPending & mainCtl_r[NP-1:0];
  wire        txActive     = txPending & mainCtl_r[MAIN_TX_BIT];
  wire        anyActive    = (|rxActive) | txActive;
  wire  [7:0] mainFlags    = {anyActive, 2'b00, txPending, 2'b00, portPending};
  wire        irqAsserted  = anyActive & mainCtl_r[MAIN_GATE_BIT];

  // Read data selection
  logic [7:0] rdMux;
  always_comb begin
    rdMux = RST_ZERO;
    if (wrPinArea) begin
      rdMux = pinCtl_r[regAddr[2:0]];
    end else if (wrSensorArea) begin
      rdMux = rxSensorStatus[rdPort][8*regAddr[1:0] +: 8];
    end else begin
      case (regAddr)
        ADDR_MAIN_CTL:      rdMux = mainCtl_r;
        ADDR_MAIN_FLAGS:    rdMux = mainFlags;
        ADDR_TX_ENABLE:     rdMux = txEnable_r;
        ADDR_TX_FLAGS:      rdMux = txFlags_r;
        ADDR_PORT_SEL:      rdMux = portSel_r;
        ADDR_RX_STS_FIRST:  rdMux = sts1Val[rdPort];
        ADDR_RX_STS_SECOND: rdMux = sts2Val[rdPort];
        ADDR_VIDEO_RX_STS:  rdMux = videoFl_r[rdPort];
        ADDR_FWD_CTL:       rdMux = fwdCtl_r[rdPort];
        ADDR_FWD_FLAGS:     rdMux = fwdFlags_r[rdPort];
        ADDR_RX_EN_UPPER:   rdMux = enUpper_r[rdPort];
        ADDR_RX_EN_LOWER:   rdMux = enLower_r[rdPort];
        ADDR_RX_FL_UPPER:   rdMux = flUpper[rdPort];
        ADDR_RX_FL_LOWER:   rdMux = flLower[rdPort];
        ADDR_SEN_RISE_MASK: rdMux = senRiseM_r[rdPort];
        ADDR_SEN_FALL_MASK: rdMux = senFallM_r[rdPort];
        ADDR_SEN_RISE_FL:   rdMux = senRiseF_r[rdPort];
        ADDR_SEN_FALL_FL:   rdMux = senFallF_r[rdPort];
        default:            rdMux = RST_ZERO;
      endcase
    end
  end

  // Global control and status registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mainCtl_r  <= RST_ZERO;
      portSel_r  <= RST_PORT_SEL;
      txEnable_r <= RST_ZERO;
      txFlags_r  <= RST_ZERO;
      txPassD_r  <= 1'b0;
      txSyncD_r  <= 1'b0;
      irqOut_n_r <= 1'b1;
      rdData_r   <= RST_ZERO;
    end else begin
      if (regWrEn && hit(regAddr, ADDR_MAIN_CTL)) mainCtl_r <= regWrData;
      if (regWrEn && hit(regAddr, ADDR_PORT_SEL)) portSel_r <= regWrData;
      if (regWrEn && hit(regAddr, ADDR_TX_ENABLE)) txEnable_r <= regWrData;
      txFlags_r  <= stick(txFlags_r, txFlagSet, rdTx);
      txPassD_r  <= txPass;
      txSyncD_r  <= txSync;
      irqOut_n_r <= ~irqAsserted;
      if (regRdEn) rdData_r <= rdMux;
    end
  end

  // Pin control registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_PINS; i++) pinCtl_r[i] <= RST_ZERO;
    end else if (regWrEn && wrPinArea) begin
      pinCtl_r[regAddr[2:0]] <= regWrData;
    end
  end

  // Per-port registers written through the port select mask
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < NP; p++) begin
        enUpper_r[p]  <= RST_ZERO;
        enLower_r[p]  <= RST_ZERO;
        fwdCtl_r[p]   <= RST_ZERO;
        senRiseM_r[p] <= RST_ZERO;
        senFallM_r[p] <= RST_ZERO;
      end
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (regWrEn && portSel_r[p]) begin
          if (hit(regAddr, ADDR_RX_EN_UPPER)) enUpper_r[p] <= regWrData;
          if (hit(regAddr, ADDR_RX_EN_LOWER)) enLower_r[p] <= regWrData;
          if (hit(regAddr, ADDR_FWD_CTL)) fwdCtl_r[p] <= regWrData;
          if (hit(regAddr, ADDR_SEN_RISE_MASK)) senRiseM_r[p] <= regWrData;
          if (hit(regAddr, ADDR_SEN_FALL_MASK)) senFallM_r[p] <= regWrData;
        end
      end
    end
  end

  // Per-port sticky flags; a set in the clearing cycle wins
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < NP; p++) begin
        sts1Fl_r[p]   <= RST_ZERO;
        sts2Fl_r[p]   <= RST_ZERO;
        videoFl_r[p]  <= RST_ZERO;
        fwdFlags_r[p] <= RST_ZERO;
        senRiseF_r[p] <= RST_ZERO;
        senFallF_r[p] <= RST_ZERO;
        senPrev_r[p]  <= RST_ZERO;
        lockD_r[p]    <= 1'b0;
        passD_r[p]    <= 1'b0;
      end
    end else begin
      for (int p = 0; p < NP; p++) begin
        sts1Fl_r[p]   <= stick(sts1Fl_r[p], sts1Set[p], clrSts1[p]);
        sts2Fl_r[p]   <= stick(sts2Fl_r[p], sts2Set[p], clrSts2[p]);
        videoFl_r[p]  <= stick(videoFl_r[p], {4'h0, rxCsiErr[p]}, clrVideo[p]);
        fwdFlags_r[p] <= stick(fwdFlags_r[p], fwdSet[p], clrFwd[p]);
        // Masked-out flags are forced to zero
        senRiseF_r[p] <= stick(senRiseF_r[p], senRiseSet[p], clrSenRise[p]) & senRiseM_r[p];
        senFallF_r[p] <= stick(senFallF_r[p], senFallSet[p], clrSenFall[p]) & senFallM_r[p];
        senPrev_r[p]  <= senByte0[p];
        lockD_r[p]    <= rxLock[p];
        passD_r[p]    <= rxPass[p];
      end
    end
  end

  // Forward pins arrive from the link: three stages, change accepted when stages two and three agree
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < NP; p++) begin
        fwdS1_r[p]  <= '0;
        fwdS2_r[p]  <= '0;
        fwdS3_r[p]  <= '0;
        fwdVal_r[p] <= '0;
      end
    end else begin
      for (int p = 0; p < NP; p++) begin
        fwdS1_r[p] <= rxFwdPin[p];
        fwdS2_r[p] <= fwdS1_r[p];
        fwdS3_r[p] <= fwdS2_r[p];
        for (int b = 0; b < NUM_FWD; b++) begin
          if (fwdS2_r[p][b] == fwdS3_r[p][b]) fwdVal_r[p][b] <= fwdS3_r[p][b];
        end
      end
    end
  end

  // General pins: register value or routed interrupt; open-drain pin only drives low
  logic [NUM_PINS-1:0] pinLevel;
  logic [NUM_PINS-1:0] pinDrive;
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pinLevel[i] = (pinCtl_r[i][PIN_SEL_LSB +: 3] == PIN_SRC_IRQ) ? irqOut_n_r
                                                                   : pinCtl_r[i][PIN_VAL_BIT];
      pinDrive[i] = pinCtl_r[i][PIN_OE_BIT];
      if (i == OPEN_DRAIN_PIN) begin
        pinDrive[i] = pinCtl_r[i][PIN_OE_BIT] & ~pinLevel[i];
      end
    end
  end

  assign pinOut    = pinLevel;
  assign pinOe_n   = ~pinDrive;
  assign irqOut_n  = irqOut_n_r;
  assign regRdData = rdData_r;
endmodule : dhi_interrupt_logic

// file: dhi_interrupt_logic_test.sv
// Purpose: Register-level test of the hub interrupt logic
// Assumes: Reads return data one edge after the strobe
// Notes:   Event inputs are one-cycle pulses
`timescale 1ns/1ps
module dhi_interrupt_logic_test;
  import dhi_pkg::*;
  logic                               core_clk = 1'b0;
  logic                               arst_n   = 1'b0;
  logic [7:0]                         regAddr  = '0;
  logic [7:0]                         regWrData = '0;
  logic                               regWrEn  = 1'b0;
  logic                               regRdEn  = 1'b0;
  logic [7:0]                         regRdData;
  logic [1:0][6:0]                    evt      = '0;
  logic [1:0][3:0]                    csiErr   = '0;
  logic [1:0]                         lock     = '0;
  logic                               txPass = 1'b0, txSync = 1'b0, txPassDeassert = 1'b0, txSyncLoss = 1'b0;
  logic                               irqOut_n;
  logic [NUM_PINS-1:0]                pinOut, pinOe_n;
  logic [NUM_PORTS-1:0][NUM_FWD-1:0]  fwdPin;
  logic [NUM_PORTS-1:0][31:0]         sensorSts;
  int                                 err_count = 0;
  int                                 check_count = 0;
  // Event order in evt: crc, seq, parity, encode, buffer, line length, line count
  localparam logic [7:0] ISR_A [7] = '{8'hda, 8'hda, 8'hdb, 8'hda, 8'hdb, 8'hdb, 8'hdb};
  localparam logic [7:0] ISR_V [7] = '{8'h01, 8'h02, 8'h04, 8'h04, 8'h10, 8'h40, 8'h20};
  localparam logic [7:0] STS_A [7] = '{8'h4d, 8'h4d, 8'h4d, 8'h4e, 8'h4e, 8'h4e, 8'h4e};
  localparam logic [7:0] STS_V [7] = '{8'h20, 8'h08, 8'h04, 8'h20, 8'h10, 8'h40, 8'h01};

  always #2.5 core_clk = ~core_clk;

  dhi_interrupt_logic dut (
    .core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdData(regRdData), .rxLock(lock), .rxPass('0),
    .rxBccCrcErr({evt[1][0], evt[0][0]}), .rxBccSeqErr({evt[1][1], evt[0][1]}),
    .rxParityErr({evt[1][2], evt[0][2]}), .rxEncodeErr({evt[1][3], evt[0][3]}),
    .rxBufferErr({evt[1][4], evt[0][4]}), .rxLineLenChg({evt[1][5], evt[0][5]}),
    .rxLineCntChg({evt[1][6], evt[0][6]}), .rxCsiErr(csiErr), .rxSensorStatus(sensorSts), .rxFwdPin(fwdPin),
    .txPass(txPass), .txSync(txSync), .txPassDeassert(txPassDeassert), .txSyncLoss(txSyncLoss),
    .irqOut_n(irqOut_n), .pinOut(pinOut), .pinOe_n(pinOe_n)
  );
  dhi_remote_model rem (.core_clk(core_clk), .fwdPin(fwdPin), .sensorSts(sensorSts));

  task automatic conclude();
    if (err_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  task automatic cmpReg(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : cmpReg

  task automatic cmpPin(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask : cmpPin

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    tick(1);
    regWrEn = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    tick(1);
    regAddr = a;
    regRdEn = 1'b1;
    tick(1);
    regRdEn = 1'b0;
    tick(1);
    cmpReg(name, exp, regRdData);
  endtask : rd

  task automatic pulse(input int p, input int k);
    tick(1);
    evt[p][k] = 1'b1;
    tick(1);
    evt[p][k] = 1'b0;
  endtask : pulse

  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    conclude();
  end

  initial begin
    tick(6);
    arst_n = 1'b1;
    rd(ADDR_MAIN_CTL, 8'h00, "main_irq_control");
    rd(ADDR_RX_EN_UPPER, 8'h00, "rx_irq_enable_upper");
    rd(8'h00, 8'h00, "unmapped");
    wr(ADDR_RX_FL_LOWER, 8'hff);
    rd(ADDR_RX_FL_LOWER, 8'h00, "rx_irq_flags_lower");
    for (int k = 0; k < 7; k++) begin
      pulse(0, k);
      rd(ISR_A[k], ISR_V[k], "flag copy");
      rd(STS_A[k], STS_V[k], "rx status");
      rd(ISR_A[k], 8'h00, "flag cleared");
    end
    csiErr[0] = 4'h2;
    tick(1);
    csiErr[0] = 4'h0;
    rd(ADDR_RX_FL_LOWER, 8'h08, "csi summary copy");
    rd(ADDR_VIDEO_RX_STS, 8'h02, "video_rx_status");
    rd(ADDR_RX_FL_LOWER, 8'h00, "csi summary cleared");
    cmpPin("irqOut_n", 1'b1, irqOut_n);
    wr(ADDR_RX_EN_LOWER, 8'h04);
    wr(ADDR_MAIN_CTL, 8'h01);
    wr(ADDR_PIN_CTL_BASE + 8'h03, 8'h21);
    wr(ADDR_PIN_CTL_BASE + 8'h05, 8'h21);
    pulse(0, 2);
    tick(2);
    cmpPin("irqOut_n", 1'b1, irqOut_n);
    rd(ADDR_MAIN_FLAGS, 8'h81, "main_irq_flags");
    wr(ADDR_MAIN_CTL, 8'h81);
    tick(2);
    cmpPin("irqOut_n", 1'b0, irqOut_n);
    cmpPin("open_drain_pin enable", 1'b0, pinOe_n[OPEN_DRAIN_PIN]);
    cmpPin("pin5 level", 1'b0, pinOut[5]);
    rd(ADDR_RX_FL_LOWER, 8'h04, "rx_irq_flags_lower");
    cmpPin("irqOut_n", 1'b0, irqOut_n);
    rd(ADDR_RX_STS_FIRST, 8'h04, "rx_status_first");
    tick(1);
    cmpPin("irqOut_n", 1'b1, irqOut_n);
    wr(ADDR_PIN_CTL_BASE + 8'h05, 8'h03);
    cmpPin("pin5 level", 1'b1, pinOut[5]);
    wr(ADDR_PORT_SEL, 8'h12);
    wr(ADDR_RX_EN_LOWER, 8'h04);
    wr(ADDR_MAIN_CTL, 8'h82);
    pulse(1, 2);
    tick(2);
    cmpPin("irqOut_n", 1'b0, irqOut_n);
    rd(ADDR_MAIN_FLAGS, 8'h82, "main_irq_flags");
    rd(ADDR_RX_STS_FIRST, 8'h44, "rx_status_first");
    wr(ADDR_PORT_SEL, 8'h01);
    wr(ADDR_TX_ENABLE, 8'h0f);
    wr(ADDR_MAIN_CTL, 8'h90);
    txPass = 1'b1;
    txSync = 1'b1;
    txPassDeassert = 1'b1;
    txSyncLoss = 1'b1;
    tick(1);
    txPassDeassert = 1'b0;
    txSyncLoss = 1'b0;
    tick(2);
    cmpPin("irqOut_n", 1'b0, irqOut_n);
    rd(ADDR_MAIN_FLAGS, 8'h90, "main_irq_flags");
    // Bit 4 still holds the receive-port pending seen earlier
    rd(ADDR_TX_FLAGS, 8'h1f, "tx flags");
    tick(1);
    cmpPin("irqOut_n", 1'b1, irqOut_n);
    // Forward-pin flags are enabled here, before the remote pulse
    wr(ADDR_FWD_CTL, 8'h21);
    rem.pulseFwd(0, 4'h3);
    tick(8);
    rd(ADDR_RX_FL_UPPER, 8'h10, "rx_irq_flags_upper");
    rd(ADDR_FWD_FLAGS, 8'h21, "fwd_pin_irq_flags");
    rd(ADDR_FWD_FLAGS, 8'h00, "fwd_pin_irq_flags");
    wr(ADDR_SEN_RISE_MASK, 8'h01);
    wr(ADDR_SEN_FALL_MASK, 8'h02);
    rem.setSensor(0, 32'h1234_5601);
    rem.setSensor(0, 32'h1234_5603);
    rem.setSensor(0, 32'h8734_5600);
    tick(2);
    rd(ADDR_SENSOR_BASE + 8'h01, 8'h56, "remote_sensor_bytes 1");
    rd(ADDR_SENSOR_BASE + 8'h03, 8'h87, "remote_sensor_bytes 3");
    rd(ADDR_RX_FL_UPPER, 8'h08, "rx_irq_flags_upper");
    rd(ADDR_SEN_RISE_FL, 8'h01, "sensor_rise_flags");
    rd(ADDR_SEN_FALL_FL, 8'h02, "sensor_fall_flags");
    rd(ADDR_RX_FL_UPPER, 8'h00, "rx_irq_flags_upper");
    lock[0] = 1'b1;
    rd(ADDR_RX_FL_LOWER, 8'h01, "lock change copy");
    rd(ADDR_RX_STS_FIRST, 8'h11, "rx_status_first lock");
    conclude();
  end
endmodule : dhi_interrupt_logic_test

// file: dhi_pkg.sv
// Purpose: Constants shared by the deserializer hub interrupt logic
// Assumes: Byte-wide register space, two receive ports
// Notes:   Offsets are byte addresses of the register port
package dhi_pkg;
  localparam int unsigned NUM_PORTS = 2;
  localparam int unsigned NUM_FWD   = 4;
  localparam int unsigned NUM_PINS  = 8;

  // Register offsets
  localparam logic [7:0] ADDR_PIN_CTL_BASE  = 8'h10;
  localparam logic [7:0] ADDR_MAIN_CTL      = 8'h23;
  localparam logic [7:0] ADDR_MAIN_FLAGS    = 8'h24;
  localparam logic [7:0] ADDR_TX_ENABLE     = 8'h36;
  localparam logic [7:0] ADDR_TX_FLAGS      = 8'h37;
  localparam logic [7:0] ADDR_PORT_SEL      = 8'h4c;
  localparam logic [7:0] ADDR_RX_STS_FIRST  = 8'h4d;
  localparam logic [7:0] ADDR_RX_STS_SECOND = 8'h4e;
  localparam logic [7:0] ADDR_FWD_CTL       = 8'h6e;
  localparam logic [7:0] ADDR_FWD_FLAGS     = 8'h6f;
  localparam logic [7:0] ADDR_VIDEO_RX_STS  = 8'h7a;
  localparam logic [7:0] ADDR_RX_EN_UPPER   = 8'hd8;
  localparam logic [7:0] ADDR_RX_EN_LOWER   = 8'hd9;
  localparam logic [7:0] ADDR_RX_FL_UPPER   = 8'hda;
  localparam logic [7:0] ADDR_RX_FL_LOWER   = 8'hdb;
  localparam logic [7:0] ADDR_SENSOR_BASE   = 8'he0;
  localparam logic [7:0] ADDR_SEN_RISE_MASK = 8'he4;
  localparam logic [7:0] ADDR_SEN_FALL_MASK = 8'he5;
  localparam logic [7:0] ADDR_SEN_RISE_FL   = 8'he6;
  localparam logic [7:0] ADDR_SEN_FALL_FL   = 8'he7;

  // Field positions
  localparam int unsigned MAIN_GATE_BIT   = 7;
  localparam int unsigned MAIN_TX_BIT     = 4;
  localparam int unsigned PSEL_RD_BIT     = 4;
  localparam int unsigned PIN_SEL_LSB     = 5;
  localparam int unsigned PIN_VAL_BIT     = 1;
  localparam int unsigned PIN_OE_BIT      = 0;
  localparam int unsigned OPEN_DRAIN_PIN  = 3;

  // Pin output source select values
  localparam logic [2:0] PIN_SRC_REG = 3'h0;
  localparam logic [2:0] PIN_SRC_IRQ = 3'h1;

  // Values after reset
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_PORT_SEL = 8'h01;
endpackage : dhi_pkg

// file: dhi_remote_model.sv
// Purpose: Remote serializer side: forward pins and sensor status
// Assumes: Changes land just after a clock edge
// Notes:   Pulses never shorter than the detectable minimum
`timescale 1ns/1ps
module dhi_remote_model (
  // Clock
  input  wire logic                                            core_clk,
  // Forward channel towards the hub
  output logic [dhi_pkg::NUM_PORTS-1:0][dhi_pkg::NUM_FWD-1:0]  fwdPin,
  output logic [dhi_pkg::NUM_PORTS-1:0][31:0]                  sensorSts
);
  import dhi_pkg::*;
  localparam int MIN_PULSE = 20; // 100 ns at 5 ns per cycle

  initial begin
    fwdPin = '0;
    sensorSts = '0;
  end

  task automatic setSensor(input int port, input logic [31:0] val);
    @(posedge core_clk);
    #1;
    sensorSts[port] = val;
  endtask : setSensor

  task automatic pulseFwd(input int port, input logic [NUM_FWD-1:0] pins);
    @(posedge core_clk);
    #1;
    fwdPin[port] = pins;
    repeat (MIN_PULSE) @(posedge core_clk);
    #1;
    fwdPin[port] = '0;
  endtask : pulseFwd
endmodule : dhi_remote_model
